// ===== design/sys_protect_pkg.sv
package sys_protect_pkg;
	// ***********************
	// Register map
	// ***********************
	localparam logic [7:0] OFS_SPC = 8'h00;
	localparam logic [7:0] OFS_WSR = 8'h04;
	localparam logic [7:0] OFS_PTR = 8'h08;
	localparam logic [7:0] OFS_PIC = 8'h0C;
	localparam logic [7:0] OFS_RCR = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;
	localparam int SPC_SWE = 7;
	localparam int SPC_SWP = 6;
	localparam int SPC_SWT = 4;
	localparam int SPC_HME = 3;
	localparam int PTR_PTP = 8;
	localparam int PIC_LVL = 8;
	localparam int STAT_PEND = 8;
	localparam logic SWE_RST = 1'h0;
	localparam logic HME_RST = 1'h0;
	localparam logic [1:0] SWT_RST = 2'h0;
	localparam logic [7:0] PITM_RST = 8'h00;
	localparam logic [2:0] PIRQL_RST = 3'h0;
	localparam logic [7:0] PIV_RST = 8'h0F;
	localparam logic [7:0] SEQ_FIRST = 8'h55;
	localparam logic [7:0] SEQ_SECOND = 8'hAA;
	localparam logic [2:0] LVL_TOP = 3'h7;
	// ***********************
	// Timing
	// ***********************
	localparam int FAST_REF_DIV = 128;
	localparam int PRESCALE_DIV = 512;
	localparam int PIT_FIXED_DIV = 4;
	localparam int WD_EXP_OFF = 9;
	localparam int WD_EXP_ON = 18;
	localparam int SPUR_WAIT = 4;

	function automatic logic [23:0] wd_limit(input logic [2:0] sel, input int trim);
		int e;
		e = (sel[2] ? WD_EXP_ON : WD_EXP_OFF) + 2 * int'(sel[1:0]) - trim;
		if (e < 1) begin
			e = 1;
		end
		return 24'((25'h0000001 << e) - 25'h0000001);
	endfunction : wd_limit
endpackage : sys_protect_pkg

// ===== design/prot_timer_if.sv
interface prot_timer_if;
	logic wd_tick;
	logic pit_tick;
	logic wd_en;
	logic watchdog_prescale_bit;
	logic [1:0] swt;
	logic service;
	logic wd_expire;
	logic periodic_prescale_bit;
	logic [7:0] modulus;
	logic pit_fire;
	logic [7:0] pit_count;
	modport ctl(output wd_tick, pit_tick, wd_en, watchdog_prescale_bit, swt, service, periodic_prescale_bit, modulus,
		input wd_expire, pit_fire, pit_count);
	modport wd(input wd_tick, wd_en, watchdog_prescale_bit, swt, service, output wd_expire);
	modport pit(input pit_tick, periodic_prescale_bit, modulus, output pit_fire, pit_count);
endinterface : prot_timer_if

// ===== design/sw_watchdog.sv
module sw_watchdog #(
	parameter int EXP_TRIM = 0
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	prot_timer_if.wd tmr
);
	logic [2:0] ratio_sel;
	logic [23:0] count;
	logic [23:0] limit;
	logic at_end;

	always_comb limit = sys_protect_pkg::wd_limit(ratio_sel, EXP_TRIM);
	always_comb at_end = tmr.wd_tick && count == limit;

	// New timeout waits for a service so a rewrite cannot cut the running period short
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || tmr.service) begin
			ratio_sel <= {tmr.watchdog_prescale_bit, tmr.swt};
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset || tmr.service || !tmr.wd_en) begin
			count <= 24'h000000;
		end else if (tmr.wd_tick) begin
			count <= at_end ? 24'h000000 : count + 24'h000001;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			tmr.wd_expire <= 1'b0;
		end else begin
			tmr.wd_expire <= tmr.wd_en && at_end && !tmr.service;
		end
	end
endmodule : sw_watchdog

// ===== design/pit_core.sv
module pit_core #(
	parameter int PRE_DIV = 512,
	parameter int FIX_DIV = 4
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	prot_timer_if.pit tmr
);
	localparam int PW = $clog2(PRE_DIV);
	localparam int QW = $clog2(FIX_DIV);
	logic [PW-1:0] pre;
	logic [QW-1:0] quarter;
	logic pre_tick;
	logic dec_tick;
	logic [7:0] count;

	always_comb pre_tick = tmr.pit_tick && (!tmr.periodic_prescale_bit || pre == PW'(PRE_DIV - 1));
	always_comb dec_tick = pre_tick && quarter == QW'(FIX_DIV - 1);

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			pre <= '0;
		end else if (tmr.pit_tick && tmr.periodic_prescale_bit) begin
			pre <= pre_tick ? '0 : pre + PW'(1);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			quarter <= '0;
		end else if (pre_tick) begin
			quarter <= dec_tick ? '0 : quarter + QW'(1);
		end
	end

	// Idle at zero; a new modulus waits for the current count to finish
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			count <= 8'h00;
		end else if (count == 8'h00) begin
			count <= tmr.modulus;
		end else if (dec_tick) begin
			count <= (count == 8'h01) ? tmr.modulus : count - 8'h01;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			tmr.pit_fire <= 1'b0;
		end else begin
			tmr.pit_fire <= dec_tick && count == 8'h01;
		end
	end

	assign tmr.pit_count = count;
endmodule : pit_core

// ===== design/sys_protect.sv
// What this block does
// - Double bus fault halt resets the chip when the halt monitor is enabled.
// - Reset cause register flags a reset produced by the halt monitor.
// - Interrupt acknowledge with no arbitration raises the bus error signal.
// - Spurious interrupt monitor is always active, no control bit disables it.
// - Enabled watchdog expiring without service asserts chip reset.
// - Each completed service sequence restarts the watchdog count from zero.
// - Watchdog clock is reference, or reference over 128 in fast mode, optional 512.
// - Watchdog prescale resets to 1 with mode pin low, 0 when high.
// - Timing field and prescale pick ratio 2^9..2^15 or 2^18..2^24.
// - New watchdog timeout applies only after a completed service sequence.
// - Periodic timer base is reference, or reference over 128 in fast mode.
// - Periodic prescale bit selects divide by 1 or 512, reset from mode pin.
// - Selected periodic clock is divided by four before the modulus counter.
// - Eight-bit modulus sets the start value; zero switches the timer off.
// - At zero the timer requests an interrupt, reloads and keeps counting.
// - A new modulus is loaded only when the current count completes.
// - Request level is compared to the core mask; 000 disables, 1..7 levels.
// - Periodic request is presented before an external one of the same level.
// - The periodic counter keeps running while its interrupt is disabled.
// - Request level 111 selects priority level seven.
// - Periodic request places the vector on the bus; vector resets to 0F.
module sys_protect #(
	parameter int FAST_REF_DIV = sys_protect_pkg::FAST_REF_DIV,
	parameter int PRESCALE_DIV = sys_protect_pkg::PRESCALE_DIV,
	parameter int WD_EXP_TRIM = 0,
	parameter int SPUR_WAIT = sys_protect_pkg::SPUR_WAIT
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_power_on,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat,
	input wire logic i_ref_clk,
	input wire logic i_clock_mode_pin,
	input wire logic i_fast_ref_pin,
	input wire logic i_halt_double_fault,
	input wire logic i_iack,
	input wire logic [2:0] i_iack_level,
	input wire logic i_ext_arb,
	input wire logic [2:0] i_core_mask,
	output logic o_chip_reset,
	output logic o_bus_error,
	output logic [2:0] o_pit_irq_level,
	output logic o_pit_recognized,
	output logic o_vector_valid,
	output logic [7:0] o_vector,
	output logic o_pit_first
);
	localparam int FW = $clog2(FAST_REF_DIV);
	localparam int SW = $clog2(SPUR_WAIT + 1);

	typedef enum logic [1:0] {IDLE, WAIT_ARB, SERVED, FAULT} iack_state_t;

	// ***********************
	// Pin synchronisers
	// ***********************
	logic [2:0] ref_sync;
	logic [1:0] mode_sync;
	logic [1:0] fast_sync;
	logic ref_edge;
	logic fast_mode;

	always_ff @(posedge i_sys_clk) begin
		ref_sync <= {ref_sync[1:0], i_ref_clk};
		mode_sync <= {mode_sync[0], i_clock_mode_pin};
		fast_sync <= {fast_sync[0], i_fast_ref_pin};
	end

	always_comb ref_edge = ref_sync[1] && !ref_sync[2];
	// Fast reference only exists with the synthesizer running
	always_comb fast_mode = mode_sync[1] && fast_sync[1];

	// ***********************
	// Reference divider
	// ***********************
	logic [FW-1:0] fdiv;
	logic base_tick;

	always_comb base_tick = ref_edge && (!fast_mode || fdiv == FW'(FAST_REF_DIV - 1));

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			fdiv <= '0;
		end else if (ref_edge && fast_mode) begin
			fdiv <= base_tick ? '0 : fdiv + FW'(1);
		end
	end

	// ***********************
	// Bus slave
	// ***********************
	logic wr;
	logic lane0;
	logic lane1;

	always_comb wr = o_wb_ack && i_wb_cyc && i_wb_stb && i_wb_we;
	always_comb lane0 = wr && i_wb_sel[0];
	always_comb lane1 = wr && i_wb_sel[1];

	// One wait state; ack drops the cycle after it is sampled
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_wb_ack <= 1'b0;
		end else begin
			o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
		end
	end

	// ***********************
	// Control registers
	// ***********************
	logic watchdog_enable_bit;
	logic watchdog_prescale_bit;
	logic [1:0] swt;
	logic halt_monitor_enable;
	logic periodic_prescale_bit;
	logic [7:0] pitm;
	logic [2:0] pirql;
	logic [7:0] piv;

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			watchdog_enable_bit <= sys_protect_pkg::SWE_RST;
			watchdog_prescale_bit <= !mode_sync[1];
			swt <= sys_protect_pkg::SWT_RST;
			halt_monitor_enable <= sys_protect_pkg::HME_RST;
		end else if (lane0 && i_wb_adr == sys_protect_pkg::OFS_SPC) begin
			watchdog_enable_bit <= i_wb_dat[sys_protect_pkg::SPC_SWE];
			watchdog_prescale_bit <= i_wb_dat[sys_protect_pkg::SPC_SWP];
			swt <= i_wb_dat[sys_protect_pkg::SPC_SWT +: 2];
			halt_monitor_enable <= i_wb_dat[sys_protect_pkg::SPC_HME];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			periodic_prescale_bit <= !mode_sync[1];
			pitm <= sys_protect_pkg::PITM_RST;
		end else if (i_wb_adr == sys_protect_pkg::OFS_PTR) begin
			if (lane1) begin
				periodic_prescale_bit <= i_wb_dat[sys_protect_pkg::PTR_PTP];
			end
			if (lane0) begin
				pitm <= i_wb_dat[7:0];
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			pirql <= sys_protect_pkg::PIRQL_RST;
			piv <= sys_protect_pkg::PIV_RST;
		end else if (i_wb_adr == sys_protect_pkg::OFS_PIC) begin
			if (lane1) begin
				pirql <= i_wb_dat[sys_protect_pkg::PIC_LVL +: 3];
			end
			if (lane0) begin
				piv <= i_wb_dat[7:0];
			end
		end
	end

	// ***********************
	// Service sequence
	// ***********************
	logic armed;
	logic service;
	logic svc_wr;

	always_comb svc_wr = lane0 && i_wb_adr == sys_protect_pkg::OFS_WSR;

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			armed <= 1'b0;
			service <= 1'b0;
		end else begin
			service <= svc_wr && armed && i_wb_dat[7:0] == sys_protect_pkg::SEQ_SECOND;
			if (svc_wr) begin
				armed <= i_wb_dat[7:0] == sys_protect_pkg::SEQ_FIRST;
			end
		end
	end

	// ***********************
	// Timers
	// ***********************
	prot_timer_if tmr ();

	assign tmr.wd_tick = base_tick;
	assign tmr.pit_tick = base_tick;
	assign tmr.wd_en = watchdog_enable_bit;
	assign tmr.watchdog_prescale_bit = watchdog_prescale_bit;
	assign tmr.swt = swt;
	assign tmr.service = service;
	assign tmr.periodic_prescale_bit = periodic_prescale_bit;
	assign tmr.modulus = pitm;

	sw_watchdog #(
		.EXP_TRIM(WD_EXP_TRIM)
	) u_wd (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.tmr(tmr.wd)
	);

	pit_core #(
		.PRE_DIV(PRESCALE_DIV),
		.FIX_DIV(sys_protect_pkg::PIT_FIXED_DIV)
	) u_pit (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.tmr(tmr.pit)
	);

	// ***********************
	// Reset generation and cause
	// ***********************
	logic halt_evt;
	logic pend_wd;
	logic pend_halt;
	logic rst_d;
	logic [3:0] rcr;

	always_comb halt_evt = i_halt_double_fault && halt_monitor_enable;

	// Chip reset holds until the reset it caused comes back in
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || i_power_on) begin
			o_chip_reset <= 1'b0;
		end else if (tmr.wd_expire || halt_evt) begin
			o_chip_reset <= 1'b1;
		end
	end

	// Cause flags survive i_reset and clear the cycle after it ends; power-on also clears them
	// A cause in the clearing cycle itself still sets its flag
	always_ff @(posedge i_sys_clk) begin
		if (i_power_on) begin
			pend_wd <= 1'b0;
			pend_halt <= 1'b0;
		end else if (!i_reset) begin
			pend_wd <= (pend_wd && !rst_d) || tmr.wd_expire;
			pend_halt <= (pend_halt && !rst_d) || halt_evt;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		rst_d <= i_reset;
		if (i_reset) begin
			rcr <= {i_power_on, pend_halt, pend_wd, !(pend_halt || pend_wd)};
		end
	end

	// ***********************
	// Interrupt side
	// ***********************
	iack_state_t state;
	logic [SW-1:0] wait_cnt;
	logic pend;
	logic pit_hit;
	logic wait_out;

	always_comb pit_hit = pend && pirql != 3'h0 && i_iack_level == pirql;
	always_comb wait_out = wait_cnt == SW'(SPUR_WAIT - 1);

	// Counter runs whatever the level; only the request is gated
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			pend <= 1'b0;
		end else if (tmr.pit_fire && pirql != 3'h0) begin
			pend <= 1'b1;
		end else if (state == IDLE && i_iack && pit_hit) begin
			pend <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			state <= IDLE;
			wait_cnt <= '0;
		end else begin
			case (state)
				IDLE: begin
					wait_cnt <= '0;
					if (i_iack) begin
						state <= (pit_hit || i_ext_arb) ? SERVED : WAIT_ARB;
					end
				end
				WAIT_ARB: begin
					wait_cnt <= wait_cnt + SW'(1);
					if (!i_iack) begin
						state <= IDLE;
					end else if (i_ext_arb) begin
						state <= SERVED;
					end else if (wait_out) begin
						state <= FAULT;
					end
				end
				SERVED, FAULT: begin
					if (!i_iack) begin
						state <= IDLE;
					end
				end
				default: begin
					state <= IDLE;
				end
			endcase
		end
	end

	// No enable term: the monitor cannot be switched off
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_bus_error <= 1'b0;
		end else begin
			o_bus_error <= i_iack && ((state == WAIT_ARB && !i_ext_arb && wait_out) || state == FAULT);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_vector_valid <= 1'b0;
			o_vector <= 8'h00;
			o_pit_first <= 1'b0;
		end else if (!i_iack) begin
			o_vector_valid <= 1'b0;
			o_pit_first <= 1'b0;
		end else if (state == IDLE && pit_hit) begin
			o_vector_valid <= 1'b1;
			o_vector <= piv;
			o_pit_first <= i_ext_arb;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_pit_irq_level <= 3'h0;
			o_pit_recognized <= 1'b0;
		end else begin
			o_pit_irq_level <= pend ? pirql : 3'h0;
			o_pit_recognized <= pend && pirql != 3'h0
				&& (pirql == sys_protect_pkg::LVL_TOP || pirql > i_core_mask);
		end
	end

	// ***********************
	// Read data
	// ***********************
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_wb_dat <= 32'h00000000;
		end else if (i_wb_cyc && i_wb_stb && !o_wb_ack) begin
			case (i_wb_adr)
				sys_protect_pkg::OFS_SPC: o_wb_dat <= {24'h000000, watchdog_enable_bit, watchdog_prescale_bit, swt, halt_monitor_enable, 3'h0};
				sys_protect_pkg::OFS_PTR: o_wb_dat <= {23'h000000, periodic_prescale_bit, pitm};
				sys_protect_pkg::OFS_PIC: o_wb_dat <= {21'h000000, pirql, piv};
				sys_protect_pkg::OFS_RCR: o_wb_dat <= {28'h0000000, rcr};
				sys_protect_pkg::OFS_STAT: o_wb_dat <= {23'h000000, pend, tmr.pit_count};
				default: o_wb_dat <= 32'h00000000;
			endcase
		end else begin
			o_wb_dat <= 32'h00000000;
		end
	end
endmodule : sys_protect

// ===== dv/sys_protect_properties.sv
module sys_protect_checker #(
	parameter int SPUR_WAIT = 4
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_power_on,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic o_wb_ack,
	input wire logic i_iack,
	input wire logic i_ext_arb,
	input wire logic o_chip_reset,
	input wire logic o_bus_error,
	input wire logic [2:0] o_pit_irq_level,
	input wire logic o_pit_recognized,
	input wire logic o_vector_valid,
	input wire logic [7:0] o_vector,
	input wire logic o_pit_first
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Checks
	// ****
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_reset);
	int wait_cnt;
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || !i_iack) begin
			wait_cnt <= 0;
		end else if (!i_ext_arb) begin
			wait_cnt <= wait_cnt + 1;
		end
	end
	sequence s_quiet_ack;
		i_iack && !i_ext_arb && !o_vector_valid;
	endsequence
	sequence s_ack_end;
		$fell(i_iack);
	endsequence
	property p_ack_wait;
		i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
	endproperty
	a_ack_wait: assert property (p_ack_wait) else $error("bus answer late");
	property p_ack_pulse;
		o_wb_ack |=> !o_wb_ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_spur;
		s_quiet_ack [*7] |=> o_bus_error;
	endproperty
	a_spur: assert property (p_spur) else $error("no bus error on unclaimed acknowledge");
	property p_spur_early;
		$rose(o_bus_error) |-> wait_cnt >= SPUR_WAIT && i_iack;
	endproperty
	a_spur_early: assert property (p_spur_early) else $error("bus error without a quiet wait");
	property p_ack_drop;
		s_ack_end |=> !o_bus_error && !o_vector_valid;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("answer held after acknowledge");
	property p_chip_hold;
		o_chip_reset && !i_power_on |=> o_chip_reset;
	endproperty
	a_chip_hold: assert property (p_chip_hold) else $error("chip reset dropped early");
	property p_recog;
		o_pit_recognized |-> o_pit_irq_level != 3'h0;
	endproperty
	a_recog: assert property (p_recog) else $error("recognized at level zero");
	property p_top;
		(o_pit_irq_level == 3'h7) [*2] |-> o_pit_recognized;
	endproperty
	a_top: assert property (p_top) else $error("level seven not recognized");
	property p_first;
		o_pit_first |-> o_vector_valid;
	endproperty
	a_first: assert property (p_first) else $error("priority flag without vector");
	property p_vec;
		o_vector_valid && $past(o_vector_valid) |-> $stable(o_vector) && $past(i_iack);
	endproperty
	a_vec: assert property (p_vec) else $error("vector unstable");
endmodule : sys_protect_checker

// ===== dv/core_model.sv
module core_model (
	input wire logic i_sys_clk,
	input wire logic i_start,
	input wire logic [2:0] i_level,
	input wire logic i_arb,
	output logic o_iack = 1'b0,
	output logic [2:0] o_iack_level = 3'h0,
	output logic o_ext_arb = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Acknowledge cycle
	// ****
	int cnt = 0;
	// Held ten cycles so a late answer still lands inside the cycle
	always @(posedge i_sys_clk) begin
		if (cnt == 0 && i_start) begin
			cnt <= 10;
			o_iack <= 1'b1;
			o_iack_level <= i_level;
			o_ext_arb <= i_arb;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end else if (cnt == 1) begin
			cnt <= 0;
			o_iack <= 1'b0;
			o_ext_arb <= 1'b0;
			o_iack_level <= ~o_iack_level;
		end
	end
endmodule : core_model

// ===== dv/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, pwr = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, refc = 1'b0, mode = 1'b0;
	logic halt = 1'b0, start = 1'b0, arb_req = 1'b0, ack, bus_error_signal, recog, vval, first, cres, iack, earb, hit;
	logic [7:0] adr = 8'h00, vec, vx;
	logic [3:0] sel = 4'h0;
	logic fast = 1'b0;
	int gap = 0;
	logic [31:0] wdat = 32'h0, rdat, q, s1;
	logic [2:0] lvl_req = 3'h0, mask = 3'h0, plvl, ilvl;
	logic [2:0] lvt [3] = '{3'h3, 3'h5, 3'h7};
	logic [2:0] mkt [3] = '{3'h2, 3'h5, 3'h7};
	logic [31:0] mdl [64];
	logic [31:0] msk [64];
	int miscompares = 0, checks_done = 0, seed = 32'h28ACDFE2;
	sys_protect #(.FAST_REF_DIV(4), .PRESCALE_DIV(8), .WD_EXP_TRIM(8), .SPUR_WAIT(4)) u_dut (.i_sys_clk(clk),
		.i_reset(rst), .i_power_on(pwr), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_ack(ack), .o_wb_dat(rdat), .i_ref_clk(refc), .i_clock_mode_pin(mode),
		.i_fast_ref_pin(fast), .i_halt_double_fault(halt), .i_iack(iack), .i_iack_level(ilvl), .i_ext_arb(earb),
		.i_core_mask(mask), .o_chip_reset(cres), .o_bus_error(bus_error_signal), .o_pit_irq_level(plvl),
		.o_pit_recognized(recog), .o_vector_valid(vval), .o_vector(vec), .o_pit_first(first));
	core_model u_core (.i_sys_clk(clk), .i_start(start), .i_level(lvl_req), .i_arb(arb_req), .o_iack(iack),
		.o_iack_level(ilvl), .o_ext_arb(earb));
	// ****
	// Clocks and tasks
	// ****
	initial begin
		forever #2 clk = ~clk;
	end
	initial begin
		forever #16 refc = ~refc;
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{cyc, stb, we} <= {2'h3, w};
		sel <= 4'h3;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		{cyc, stb, we} <= 3'h0;
		sel <= 4'h0;
		if (n >= 20) begin
			miscompares++;
			final_report();
		end
		if (w) begin
			mdl[a[7:2]] = d & msk[a[7:2]];
		end
	endtask : wb
	task automatic rd(input logic [7:0] a);
		wb(1'b0, a, 32'h0);
		chk(q, mdl[a[7:2]]);
	endtask : rd
	task automatic svc(input logic [7:0] b1, input logic [7:0] b2);
		wb(1'b1, 8'h04, {24'h0, b1});
		wb(1'b1, 8'h08, mdl[2]);
		wb(1'b1, 8'h04, {24'h0, b2});
	endtask : svc
	// Cycles between two changes of the periodic count; reads come every three cycles
	task automatic pit_gap(output int g);
		logic [7:0] c0;
		int n;
		n = 0;
		g = 0;
		wb(1'b0, 8'h14, 32'h0);
		c0 = q[7:0];
		for (int e = 0; e < 2; e++) begin
			g = 0;
			do begin
				wb(1'b0, 8'h14, 32'h0);
				n++;
				g = g + 3;
			end while (q[7:0] === c0 && n < 400);
			c0 = q[7:0];
		end
		if (n >= 400) begin
			miscompares++;
			final_report();
		end
	endtask : pit_gap
	// Bounded wait; a required event that never comes ends the run
	task automatic wt(input int which, input int lim, input logic must);
		hit = 1'b0;
		repeat (lim) begin
			@(posedge clk);
			if ((which == 0 && cres === 1'b1) || (which == 1 && plvl === lvl_req) || (which == 2 && bus_error_signal === 1'b1)
				|| (which == 3 && vval === 1'b1)) begin
				hit = 1'b1;
				break;
			end
		end
		if (must && !hit) begin
			miscompares++;
			final_report();
		end
	endtask : wt
	task automatic do_reset(input logic m, input logic p);
		@(posedge clk);
		rst <= 1'b1;
		pwr <= p;
		mode <= m;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		pwr <= 1'b0;
		mdl = '{default: 32'h0};
		mdl[0] = {25'h0, ~m, 6'h0};
		mdl[2] = {23'h0, ~m, 8'h0};
		mdl[3] = 32'h0000000F;
	endtask : do_reset
	// ****
	// Scenarios
	// ****
	initial begin
		msk = '{default: 32'h0};
		msk[0] = 32'hF8;
		msk[2] = 32'h1FF;
		msk[3] = 32'h7FF;
		for (int m = 0; m < 2; m++) begin
			do_reset(m[0], 1'b1);
			rd(8'h00);
			rd(8'h08);
			rd(8'h0C);
			rd(8'h20);
		end
		wb(1'b1, 8'h00, 32'h10);
		svc(8'h55, 8'hAA);
		wb(1'b1, 8'h00, 32'h90);
		repeat (6) begin
			svc(8'h55, 8'hAA);
			repeat (16) @(posedge clk);
		end
		chk({31'h0, cres}, 32'h0);
		svc(8'h55, 8'h5A);
		wb(1'b1, 8'h04, 32'hAA);
		wt(0, 200, 1'b1);
		do_reset(1'b1, 1'b0);
		wb(1'b0, 8'h10, 32'h0);
		chk(q, 32'h2);
		for (int h = 0; h < 2; h++) begin
			wb(1'b1, 8'h00, {28'h0, h[0], 3'h0});
			halt <= 1'b1;
			@(posedge clk);
			halt <= 1'b0;
			wt(0, 20, 1'b0);
			chk({31'h0, hit}, {31'h0, h[0]});
		end
		do_reset(1'b1, 1'b0);
		wb(1'b0, 8'h10, 32'h0);
		chk(q, 32'h4);
		for (int a = 0; a < 2; a++) begin
			arb_req <= a[0];
			start <= 1'b1;
			@(posedge clk);
			start <= 1'b0;
			wt(2, 14, 1'b0);
			chk({31'h0, hit}, {31'h0, ~a[0]});
			repeat (16) @(posedge clk);
		end
		for (int k = 0; k < 3; k++) begin
			vx = 8'($random(seed));
			lvl_req <= lvt[k];
			mask <= mkt[k];
			wb(1'b1, 8'h0C, {21'h0, lvt[k], vx});
			wb(1'b1, 8'h08, 32'h2);
			wt(1, 300, 1'b1);
			repeat (3) @(posedge clk);
			chk({31'h0, recog}, {31'h0, k != 1});
			start <= 1'b1;
			@(posedge clk);
			start <= 1'b0;
			wt(3, 10, 1'b1);
			@(posedge clk);
			chk({23'h0, first, vec}, {23'h0, 1'b1, vx});
			repeat (16) @(posedge clk);
			rd(8'h0C);
		end
		wb(1'b1, 8'h0C, 32'h0F);
		wb(1'b1, 8'h08, 32'h5);
		repeat (40) @(posedge clk);
		wb(1'b0, 8'h14, 32'h0);
		s1 = q;
		repeat (40) @(posedge clk);
		wb(1'b0, 8'h14, 32'h0);
		chk({31'h0, s1[7:0] == q[7:0]}, 32'h0);
		// Four base ticks per step; a reference edge every eight cycles, four of them per tick when fast
		for (int f = 0; f < 2; f++) begin
			fast <= f[0];
			repeat (8) @(posedge clk);
			pit_gap(gap);
			chk({31'h0, gap >= 4 * 8 * (f ? 4 : 1) - 3 && gap <= 4 * 8 * (f ? 4 : 1) + 3}, 32'h1);
		end
		final_report();
	end
endmodule : tb
bind sys_protect sys_protect_checker #(.SPUR_WAIT(SPUR_WAIT)) u_chk (.i_sys_clk, .i_reset, .i_power_on, .i_wb_cyc,
	.i_wb_stb, .o_wb_ack, .i_iack, .i_ext_arb, .o_chip_reset, .o_bus_error, .o_pit_irq_level, .o_pit_recognized,
	.o_vector_valid, .o_vector, .o_pit_first);
